// ---- rtl/debug_breakpoint_trace_unit.sv ----
// debug breakpoint comparator, trigger logic and eight-entry capture fifo
// Functional notes
// - simple breakpoint compares each address to match
// - forced: any access breaks at next boundary
// - tagged: mark opcode, break if it executes
// - simple breakpoint idle while enable is zero
// - force select one forced, zero tagged
// - eight-entry fifo of address or data
// - comparators A and B with direction qualify
// - opcode tracking triggers only on execution, except in data and range modes
// - magnitude compares for inside and outside range
// - comparators muted during debug controller accesses
// - A on address, B address or data
// - write data when qualify one, direction write
// - match breaks, stores data, starts or stops capture
// - manual halt shifts contents, host dummy reads
// - high then low read, low read shifts
// - event modes store bytes, low reads only
// - skip change-of-flow at trigger and two cycles
// - end trace stores change-of-flow trigger last
// - disarmed low read pushes last opcode address
// - taken conditional branch stores branch address
// - indirect jump, call, interrupt, return store destination
// - tag request travels with opcode in queue
// - arm write sets flag, clears flags, count
// - begin run ends full, end run on trigger
`timescale 1ns/1ps
`include "dbg_regs.svh"
module debug_breakpoint_trace_unit
    import dbg_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire cpu_bus_t    bus_i,
    input  wire cof_t        cof_i,
    input  wire iq_t         iq_i,
    input  wire logic [15:0] last_opcode_addr_i,
    input  wire logic        simple_break_enable_i,
    input  wire logic        force_select_i,
    input  wire logic [15:0] simple_break_match_value_i,
    input  wire trace_cfg_t  cfg_i,
    input  wire logic        fifo_high_read_i,
    input  wire logic        fifo_low_read_i,
    output logic             force_break_o,
    output logic             tag_break_o,
    output logic [7:0]       fifo_high_byte_o,
    output logic [7:0]       fifo_low_byte_o,
    output logic [3:0]       fifo_valid_count_o,
    output logic             capture_run_active_flag_o,
    output logic             comp_a_flag_o,
    output logic             comp_b_flag_o
);
    typedef struct packed {
        logic [DEPTH-1:0][15:0] mem;
        logic [3:0]             cnt;
        logic                   armed;
        logic                   a_flag;
        logic                   b_flag;
        logic                   a_seen;
        logic                   capturing;
        logic [1:0]             skip;
        logic                   force_brk;
        logic                   tag_brk;
        logic [7:0]             high_byte;
        logic [7:0]             low_byte;
    } state_t;

    state_t s_q, s_d;

    logic        a_eq, b_eq, a_ge, b_le, a_dir_ok, b_dir_ok, dir_ok_a, dir_ok_b;
    logic [7:0]  b_data;
    logic        comp_en, raw_a, raw_b, data_eq, hit_a, hit_b;
    logic        trig, event_mode, is_cof, push;
    logic [15:0] cof_addr, push_val;
    logic        simple_hit;
    logic        stop_shift;

    // comparator front end, muted on debugger cycles
    always_comb begin
        comp_en  = bus_i.valid && !bus_i.debug_access;
        a_eq     = bus_i.addr == cfg_i.comp_a_value;
        b_eq     = bus_i.addr == cfg_i.comp_b_value;
        a_ge     = bus_i.addr >= cfg_i.comp_a_value;
        b_le     = bus_i.addr <= cfg_i.comp_b_value;
        // write bus only when qualified as a write
        b_data   = (cfg_i.comp_a_direction_qualify && !cfg_i.comp_a_expected_direction)
                   ? bus_i.wdata : bus_i.rdata;
        data_eq  = b_data == cfg_i.comp_b_value[7:0];
        dir_ok_a = !cfg_i.comp_a_direction_qualify
                   || (bus_i.is_read == cfg_i.comp_a_expected_direction);
        dir_ok_b = !cfg_i.comp_b_direction_qualify
                   || (bus_i.is_read == cfg_i.comp_b_expected_direction);
        a_dir_ok = comp_en && dir_ok_a;
        b_dir_ok = comp_en && dir_ok_b;
        raw_a    = a_dir_ok && a_eq;
        raw_b    = b_dir_ok && b_eq;
    end

    // opcode tracking: one select for both comparators, fires on execution of queue head
    always_comb begin
        if (cfg_i.opcode_tracking_select) begin
            hit_a = iq_i.exec && iq_i.exec_addr == cfg_i.comp_a_value;
            hit_b = iq_i.exec && iq_i.exec_addr == cfg_i.comp_b_value;
        end else begin
            hit_a = raw_a;
            hit_b = raw_b;
        end
    end

    // trigger decode per mode
    always_comb begin
        event_mode = (cfg_i.mode == TRG_EVENT_B) || (cfg_i.mode == TRG_A_THEN_EVENT_B);
        unique case (cfg_i.mode)
            TRG_A_ONLY:           trig = hit_a;
            TRG_A_OR_B:           trig = hit_a || hit_b;
            TRG_A_THEN_B:         trig = s_q.a_seen && hit_b;
            TRG_EVENT_B:          trig = hit_b;
            TRG_A_THEN_EVENT_B:   trig = s_q.a_seen && hit_b;
            TRG_A_AND_B_DATA:     trig = raw_a && data_eq;
            TRG_A_AND_NOT_B_DATA: trig = raw_a && !data_eq;
            TRG_INSIDE:           trig = a_dir_ok && a_ge && b_le;
            TRG_OUTSIDE:          trig = a_dir_ok && !(a_ge && b_le);
            default:              trig = 1'b0;
        endcase
        trig = trig && cfg_i.trace_enable;
    end

    // change-of-flow source; unconditional branches never recorded
    always_comb begin
        is_cof   = 1'b0;
        cof_addr = `ADDR_RST;
        if (cof_i.cond_branch_taken && !cof_i.branch_always_instr
            && !cof_i.branch_never_instr) begin
            is_cof   = 1'b1;
            cof_addr = cof_i.branch_addr;
        end else if (cof_i.indirect_jump || cof_i.interrupt_or_return) begin
            is_cof   = 1'b1;
            cof_addr = cof_i.dest_addr;
        end
    end

    assign simple_hit = simple_break_enable_i && comp_en
                        && bus_i.addr == simple_break_match_value_i;

    // next state
    always_comb begin
        s_d       = s_q;
        push      = 1'b0;
        push_val  = `ADDR_RST;
        s_d.force_brk = 1'b0;
        s_d.tag_brk   = 1'b0;

        // simple breakpoint, disabled while enable is low
        if (simple_hit) begin
            if (force_select_i) begin
                s_d.force_brk = 1'b1;
            end else if (bus_i.opcode_fetch) begin
                s_d.tag_brk = 1'b1;
            end
        end
        // trace unit breakpoint; full modes tag on the A address only
        if (cfg_i.break_enable && s_q.armed) begin
            if (cfg_i.tag_select) begin
                if ((cfg_i.mode == TRG_A_AND_B_DATA || cfg_i.mode == TRG_A_AND_NOT_B_DATA)
                    ? raw_a : trig)
                    s_d.tag_brk = 1'b1;
            end else if (trig) begin
                s_d.force_brk = 1'b1;
            end
        end

        if (s_q.armed) begin
            if (hit_a)
                s_d.a_seen = 1'b1;
            if (hit_a)
                s_d.a_flag = 1'b1;
            if (hit_b)
                s_d.b_flag = 1'b1;
            if (s_q.skip != 2'h0)
                s_d.skip = s_q.skip - 2'h1;
            if (event_mode) begin
                // byte capture on each trigger, begin type always
                if (trig) begin
                    push     = 1'b1;
                    push_val = {`DATA_RST, b_data};
                end
            end else if (cfg_i.begin_trace) begin
                if (s_q.capturing && s_q.skip == 2'h0 && is_cof) begin
                    push     = 1'b1;
                    push_val = cof_addr;
                end
                if (!s_q.capturing && trig) begin
                    s_d.capturing = 1'b1;
                    s_d.skip      = `COF_SKIP_CYC;
                end
            end else begin
                // end trace: circular capture until the trigger
                if (is_cof) begin
                    push     = 1'b1;
                    push_val = cof_addr;
                end
                if (trig)
                    s_d.armed = 1'b0;
            end
        end else if (fifo_low_read_i) begin
            push     = 1'b1;
            push_val = last_opcode_addr_i;
        end

        // manual stop before full drops the head once; host then needs one dummy read fewer
        stop_shift = cfg_i.arm_write && !cfg_i.arm_value && s_q.armed
                     && s_q.cnt != `FIFO_DEPTH;
        // low byte read shifts the fifo; a push shifts in at the tail
        if (fifo_low_read_i || push || stop_shift) begin
            for (int i = 0; i < DEPTH - 1; i++)
                s_d.mem[i] = s_q.mem[i+1];
            s_d.mem[DEPTH-1] = push ? push_val : `ADDR_RST;
        end
        if (push && s_q.armed) begin
            if (s_q.cnt != `FIFO_DEPTH)
                s_d.cnt = s_q.cnt + `CNT_ONE;
            if ((event_mode || cfg_i.begin_trace) && s_q.cnt == `FIFO_DEPTH - `CNT_ONE)
                s_d.armed = 1'b0;
        end
        // data port shows the head of the fifo
        s_d.high_byte = s_d.mem[0][15:8];
        s_d.low_byte  = s_d.mem[0][7:0];

        // arm and manual stop; arming wins over the rest of the cycle, except that a low trace_enable still clears armed
        if (cfg_i.arm_write) begin
            if (cfg_i.arm_value) begin
                s_d.armed     = 1'b1;
                s_d.a_flag    = 1'b0;
                s_d.b_flag    = 1'b0;
                s_d.cnt       = `FIFO_CNT_RST;
                s_d.a_seen    = 1'b0;
                s_d.capturing = 1'b0;
                s_d.skip      = 2'h0;
            end else begin
                s_d.armed = 1'b0;
            end
        end
        if (!cfg_i.trace_enable)
            s_d.armed = 1'b0;
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign force_break_o             = s_q.force_brk;
    assign tag_break_o               = s_q.tag_brk;
    assign fifo_high_byte_o          = s_q.high_byte;
    assign fifo_low_byte_o           = s_q.low_byte;
    assign fifo_valid_count_o        = s_q.cnt;
    assign capture_run_active_flag_o = s_q.armed;
    assign comp_a_flag_o             = s_q.a_flag;
    assign comp_b_flag_o             = s_q.b_flag;
endmodule : debug_breakpoint_trace_unit

// ---- rtl/dbg_regs.svh ----
// constants for the debug breakpoint and trace unit
`ifndef DBG_REGS_SVH
`define DBG_REGS_SVH
`define FIFO_DEPTH      4'h8
`define FIFO_CNT_RST    4'h0
`define COF_SKIP_CYC    2'h2
`define CNT_ONE         4'h1
`define ADDR_RST        16'h0000
`define DATA_RST        8'h00
`endif

// ---- rtl/dbg_pkg.sv ----
// types for the debug breakpoint and trace unit
package dbg_pkg;
    typedef enum logic [3:0] {
        TRG_A_ONLY, TRG_A_OR_B, TRG_A_THEN_B, TRG_EVENT_B, TRG_A_THEN_EVENT_B,
        TRG_A_AND_B_DATA, TRG_A_AND_NOT_B_DATA, TRG_INSIDE, TRG_OUTSIDE
    } trig_mode_t;

    // one cpu bus cycle as seen by the debug logic
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  rdata;
        logic [7:0]  wdata;
        logic        is_read;
        logic        opcode_fetch;
        logic        debug_access;
    } cpu_bus_t;

    // change-of-flow report from the cpu
    typedef struct packed {
        logic        cond_branch_taken;
        logic        branch_always_instr;
        logic        branch_never_instr;
        logic        indirect_jump;
        logic        interrupt_or_return;
        logic [15:0] branch_addr;
        logic [15:0] dest_addr;
    } cof_t;

    // instruction queue: tag entry, execution of queue head
    typedef struct packed {
        logic        exec;
        logic [15:0] exec_addr;
        logic        exec_tag;
    } iq_t;

    typedef struct packed {
        logic        arm_write;
        logic        arm_value;
        logic        trace_enable;
        logic        break_enable;
        logic        tag_select;
        logic        begin_trace;
        trig_mode_t  mode;
        logic        opcode_tracking_select;
        logic        comp_a_direction_qualify;
        logic        comp_a_expected_direction;
        logic        comp_b_direction_qualify;
        logic        comp_b_expected_direction;
        logic [15:0] comp_a_value;
        logic [15:0] comp_b_value;
    } trace_cfg_t;
endpackage : dbg_pkg

// ---- bench/debug_breakpoint_trace_unit_sva.sv ----
// assertion checker for the debug breakpoint and trace unit
`timescale 1ns/1ps
module debug_breakpoint_trace_unit_chk
    import dbg_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire cpu_bus_t    bus_i,
    input  wire iq_t         iq_i,
    input  wire logic        simple_break_enable_i,
    input  wire logic        force_select_i,
    input  wire logic [15:0] simple_break_match_value_i,
    input  wire trace_cfg_t  cfg_i,
    input  wire logic        force_break_o,
    input  wire logic        tag_break_o,
    input  wire logic [3:0]  fifo_valid_count_o,
    input  wire logic        capture_run_active_flag_o,
    input  wire logic        comp_a_flag_o,
    input  wire logic        comp_b_flag_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // live cpu cycle on the simple match address; debugger cycles left out
    wire logic hit = bus_i.valid && !bus_i.debug_access && bus_i.addr == simple_break_match_value_i;
    property p_force_hit;
        simple_break_enable_i && force_select_i && hit |=> force_break_o;
    endproperty
    a_force_hit: assert property (p_force_hit) else $error("forced break missing");
    property p_tag_hit;
        simple_break_enable_i && !force_select_i && hit && bus_i.opcode_fetch |=> tag_break_o;
    endproperty
    a_tag_hit: assert property (p_tag_hit) else $error("tag request missing");
    property p_brk_off;
        !simple_break_enable_i && !cfg_i.break_enable |=> !force_break_o && !tag_break_o;
    endproperty
    a_brk_off: assert property (p_brk_off) else $error("break while disabled");
    property p_arm;
        cfg_i.arm_write && cfg_i.arm_value |=> capture_run_active_flag_o && fifo_valid_count_o == 4'h0
            && !comp_a_flag_o && !comp_b_flag_o;
    endproperty
    a_arm: assert property (p_arm) else $error("arming did not start a clean run");
    property p_cnt_max;
        fifo_valid_count_o <= DEPTH;
    endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("count above depth");
    property p_cnt_step;
        fifo_valid_count_o <= $past(fifo_valid_count_o) + 4'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count jumped by more than one");
    // a begin run stops once the fifo is full; the one-cycle slack covers either register order
    property p_full_stop;
        $rose(fifo_valid_count_o == 4'h8) && (cfg_i.begin_trace || cfg_i.mode == TRG_EVENT_B)
            && !cfg_i.arm_write |-> ##[0:1] !capture_run_active_flag_o;
    endproperty
    a_full_stop: assert property (p_full_stop) else $error("full begin run kept going");
    property p_mute;
        bus_i.valid && bus_i.debug_access && !iq_i.exec && !cfg_i.arm_write && !comp_a_flag_o
            && !comp_b_flag_o |=> !comp_a_flag_o && !comp_b_flag_o;
    endproperty
    a_mute: assert property (p_mute) else $error("debugger cycle matched");
    c_force: cover property (force_break_o);
    c_tag: cover property (tag_break_o);
    c_full: cover property (fifo_valid_count_o == 4'h8);
endmodule : debug_breakpoint_trace_unit_chk

bind debug_breakpoint_trace_unit debug_breakpoint_trace_unit_chk #(.DEPTH(DEPTH)) chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .iq_i(iq_i),
    .simple_break_enable_i(simple_break_enable_i), .force_select_i(force_select_i),
    .simple_break_match_value_i(simple_break_match_value_i), .cfg_i(cfg_i), .force_break_o(force_break_o),
    .tag_break_o(tag_break_o), .fifo_valid_count_o(fifo_valid_count_o),
    .capture_run_active_flag_o(capture_run_active_flag_o), .comp_a_flag_o(comp_a_flag_o),
    .comp_b_flag_o(comp_b_flag_o));

// ---- bench/cpu_core_model.sv ----
// behavioural cpu core: bus cycles and change-of-flow reports
`timescale 1ns/1ps
module cpu_core_model
    import dbg_pkg::*;
(
    input  wire logic        sys_clk_i,
    output cpu_bus_t         bus_o,
    output cof_t             cof_o,
    output iq_t              iq_o,
    output logic [15:0]      last_op_o
);
    // queue idle except while the exec task reports an execution of its head
    initial begin
        bus_o = '0;
        cof_o = '0;
        iq_o = '0;
        last_op_o = 16'h0000;
    end
    // one live cycle; the unused data bus carries the inverse, not a copy
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic rd, input logic f, input logic dbg,
                       input cof_t c);
        @(negedge sys_clk_i) bus_o = '{1'b1, a, rd ? d : ~d, rd ? ~d : d, rd, f, dbg};
        cof_o = c;
    endtask : cyc
    // flow report with the bus idle; a released address keeps moving
    task automatic flow(input cof_t c);
        @(negedge sys_clk_i) cof_o = c;
        bus_o.valid = 1'b0;
        bus_o.addr = ~bus_o.addr;
    endtask : flow
    // queue head executes at address a for one cycle, bus idle
    task automatic exec(input logic [15:0] a);
        @(negedge sys_clk_i) iq_o = '{1'b1, a, 1'b0};
        bus_o.valid = 1'b0;
        @(negedge sys_clk_i) iq_o = '0;
    endtask : exec
    task automatic idle();
        flow('0);
    endtask : idle
endmodule : cpu_core_model

// ---- bench/debug_breakpoint_trace_unit_tb.sv ----
// self-checking testbench for the debug breakpoint and trace unit
`timescale 1ns/1ps
module debug_breakpoint_trace_unit_tb
    import dbg_pkg::*;
;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        simple_break_enable_i = 1'b0;
    logic        force_select_i = 1'b0;
    logic [15:0] simple_break_match_value_i = 16'h0000;
    trace_cfg_t  cfg = '0;
    logic        fifo_high_read_i = 1'b0;
    logic        fifo_low_read_i = 1'b0;
    cpu_bus_t    bus;
    cof_t        cof;
    iq_t         iq;
    logic [15:0] last_op;
    logic [7:0]  hi_b, lo_b;
    logic [3:0]  cnt;
    logic        fbrk, tbrk, armed, fa, fb;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cycles = 0;
    cpu_core_model cpu (.sys_clk_i(sys_clk_i), .bus_o(bus), .cof_o(cof), .iq_o(iq), .last_op_o(last_op));
    debug_breakpoint_trace_unit #(.DEPTH(8)) DUT (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .cof_i(cof), .iq_i(iq),
        .last_opcode_addr_i(last_op), .simple_break_enable_i(simple_break_enable_i),
        .force_select_i(force_select_i), .simple_break_match_value_i(simple_break_match_value_i), .cfg_i(cfg),
        .fifo_high_read_i(fifo_high_read_i), .fifo_low_read_i(fifo_low_read_i), .force_break_o(fbrk),
        .tag_break_o(tbrk), .fifo_high_byte_o(hi_b), .fifo_low_byte_o(lo_b), .fifo_valid_count_o(cnt),
        .capture_run_active_flag_o(armed), .comp_a_flag_o(fa), .comp_b_flag_o(fb));
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // a whole run is about a hundred cycles; anything near this is a hang
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic arm(input logic v);
        @(negedge sys_clk_i) cfg.arm_write = 1'b1;
        cfg.arm_value = v;
        @(negedge sys_clk_i) cfg.arm_write = 1'b0;
    endtask : arm
    // optional high read, then the low read that shifts the fifo
    task automatic pop(input logic hi, input logic [15:0] exp, input string what);
        logic [7:0] h;
        h = hi_b;
        if (hi) begin
            @(negedge sys_clk_i) fifo_high_read_i = 1'b1;
            h = hi_b;
        end
        @(negedge sys_clk_i) fifo_high_read_i = 1'b0;
        fifo_low_read_i = 1'b1;
        check(what, {h, lo_b}, exp);
        @(negedge sys_clk_i) fifo_low_read_i = 1'b0;
    endtask : pop
    initial begin
        repeat (10) @(posedge sys_clk_i);
        @(negedge sys_clk_i) sys_rst_i = 1'b0;
        // simple breakpoint: forced, tagged, disabled
        check("idle_break", {fbrk, tbrk}, 16'h0000);
        simple_break_match_value_i = 16'h1234;
        simple_break_enable_i = 1'b1;
        force_select_i = 1'b1;
        cpu.cyc(16'h1234, 8'h5A, 1'b0, 1'b0, 1'b0, '0);
        cpu.idle();
        check("force_on_write", {fbrk, tbrk}, 16'h0002);
        force_select_i = 1'b0;
        cpu.cyc(16'h1234, 8'h5A, 1'b1, 1'b0, 1'b0, '0);
        cpu.cyc(16'h1234, 8'h9D, 1'b1, 1'b1, 1'b0, '0);
        check("tag_data_read", {fbrk, tbrk}, 16'h0000);
        cpu.idle();
        check("tag_fetch", {fbrk, tbrk}, 16'h0001);
        simple_break_enable_i = 1'b0;
        cpu.cyc(16'h1234, 8'h9D, 1'b1, 1'b1, 1'b0, '0);
        cpu.idle();
        check("disabled", {fbrk, tbrk}, 16'h0000);
        $display("test simple_break done");
        // event-only run: bytes captured until full, then profiling pushes
        cfg.mode = TRG_EVENT_B;
        cfg.comp_b_value = 16'h0200;
        cfg.trace_enable = 1'b1;
        arm(1'b1);
        check("arm", {armed, fa, fb, cnt}, 16'h0040);
        cpu.cyc(16'h0200, 8'h77, 1'b1, 1'b0, 1'b1, '0);
        cpu.idle();
        check("muted", {fb, cnt}, 16'h0000);
        for (int i = 0; i < 9; i++)
            cpu.cyc(16'h0200, 8'(8'hA0 + i), 1'b1, 1'b0, 1'b0, '0);
        cpu.idle();
        check("full", {armed, cnt}, 16'h0008);
        for (int i = 0; i < 8; i++) begin
            cpu.last_op_o = 16'(16'h4000 + i);
            pop(1'b0, 16'(16'h00A0 + i), "event_byte");
        end
        cfg.mode = TRG_A_ONLY;
        for (int i = 0; i < 8; i++)
            pop(1'b1, 16'(16'h4000 + i), "profile");
        $display("test event_profile done");
        // begin trace: trigger and two following flows skipped, bra and brn ignored
        cfg.comp_a_value = 16'h0300;
        cfg.begin_trace = 1'b1;
        arm(1'b1);
        cpu.cyc(16'h0300, 8'h00, 1'b1, 1'b1, 1'b0, cof_t'({5'b10000, 16'h1000, 16'hE000}));
        cpu.flow(cof_t'({5'b10000, 16'h1111, 16'hEEEE}));
        cpu.flow(cof_t'({5'b10000, 16'h2222, 16'hDDDD}));
        cpu.flow(cof_t'({5'b11000, 16'h3333, 16'hCCCC}));
        cpu.flow(cof_t'({5'b10000, 16'h4444, 16'hBBBB}));
        cpu.flow(cof_t'({5'b10100, 16'h5555, 16'hAAAA}));
        cpu.flow(cof_t'({5'b00010, 16'h0000, 16'h6666}));
        cpu.flow(cof_t'({5'b00001, 16'h0000, 16'h7777}));
        cpu.idle();
        check("cof_count", {armed, fa, cnt}, 16'h0033);
        arm(1'b0);
        // manual stop at count three: (8 - 3) - 1 dummy reads
        repeat (4) begin
            @(negedge sys_clk_i) fifo_low_read_i = 1'b1;
            @(negedge sys_clk_i) fifo_low_read_i = 1'b0;
        end
        pop(1'b1, 16'h4444, "cond_branch");
        pop(1'b1, 16'h6666, "indirect_dest");
        pop(1'b1, 16'h7777, "return_dest");
        $display("test begin_trace done");
        // end trace with opcode tracking: a fetch alone does not trigger, execution does
        cfg.opcode_tracking_select = 1'b1;
        cfg.begin_trace = 1'b0;
        cfg.comp_a_value = 16'h0500;
        arm(1'b1);
        cpu.cyc(16'h0500, 8'h00, 1'b1, 1'b1, 1'b0, '0);
        cpu.idle();
        check("track_fetch", {armed, fa}, 16'h0002);
        cpu.exec(16'h0500);
        check("track_exec", {armed, fa}, 16'h0001);
        $display("test tracking done");
        summarize();
    end
endmodule : debug_breakpoint_trace_unit_tb
